//--- core/uart_cfg_map.vh
// Register offsets, field positions, command codes and fill thresholds for the channel configuration block
`ifndef UART_CFG_MAP_VH
`define UART_CFG_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_MODE 4'h0
`define OFS_STATUS 4'h1
`define OFS_COMMAND 4'h2
`define OFS_HOLDING 4'h3
`define OFS_OUT_LATCH 4'h4
`define OFS_INT_STATE 4'h5

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE0_RX_LEVEL_HI 6
`define MODE0_TX_LEVEL_HI 5
`define MODE0_TX_LEVEL_LO 4
`define MODE0_DEPTH_SEL 3
`define MODE1_FLOW_CTRL 7
`define MODE1_RX_LEVEL_LO 6
`define MODE1_ERR_MODE 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MODE0_RESET 8'h00
`define MODE1_RESET 8'h00
`define MODE2_RESET 8'h00
`define OUT_LATCH_RESET 8'h00

// ----------------------------------------------------------------
// Command register: bits 7:4 code, bits 3:0 enables and disables
// ----------------------------------------------------------------
`define CMD_NOP 4'h0
`define CMD_PTR_MODE1 4'h1
`define CMD_RX_RESET 4'h2
`define CMD_TX_RESET 4'h3
`define CMD_ERR_RESET 4'h4
`define CMD_PTR_MODE0 4'hB
`define CMD_RX_EN 0
`define CMD_RX_DIS 1
`define CMD_TX_EN 2
`define CMD_TX_DIS 3

// ----------------------------------------------------------------
// Queue depths and interrupt thresholds
// ----------------------------------------------------------------
`define DEPTH_SHALLOW 5'h08
`define DEPTH_DEEP 5'h10
`define RX8_L0 5'h01
`define RX8_L1 5'h03
`define RX8_L2 5'h06
`define RX8_L3 5'h08
`define RX16_L0 5'h01
`define RX16_L1 5'h08
`define RX16_L2 5'h0C
`define RX16_L3 5'h10
`define TX8_L0 5'h08
`define TX8_L1 5'h04
`define TX8_L2 5'h06
`define TX8_L3 5'h01
`define TX16_L0 5'h10
`define TX16_L1 5'h08
`define TX16_L2 5'h0C
`define TX16_L3 5'h01

`endif

//--- core/char_queue.v
// Character queue of sixteen entries with selectable eight-entry limit
`timescale 1ns/100ps
`default_nettype none
`include "uart_cfg_map.vh"

module char_queue #(
	parameter W = 8
) (
	// Clock and reset
	input wire core_clk_i,
	input wire rstn_i,
	// Control
	input wire flush_i,
	input wire deep_i,
	// Fill side
	input wire push_i,
	input wire [W-1:0] push_data_i,
	// Drain side
	input wire pop_i,
	output wire [W-1:0] head_o,
	// State
	output wire [4:0] fill_o,
	output wire full_o
);

	reg [W-1:0] mem [0:15];
	reg [3:0] rd_q;
	reg [3:0] wr_q;
	reg [4:0] fill_q;
	wire [4:0] limit;
	wire do_push;
	wire do_pop;

	assign limit = deep_i ? `DEPTH_DEEP : `DEPTH_SHALLOW;
	assign full_o = (fill_q >= limit);
	assign fill_o = fill_q;
	assign head_o = mem[rd_q];
	// Push refused when full, pop refused when empty
	assign do_push = push_i && !full_o && !flush_i;
	assign do_pop = pop_i && (fill_q != 5'h00) && !flush_i;

	always @(posedge core_clk_i) begin
		if (do_push) begin
			mem[wr_q] <= push_data_i;
		end
	end

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_q <= 4'h0;
			wr_q <= 4'h0;
			fill_q <= 5'h00;
		end else if (flush_i) begin
			rd_q <= 4'h0;
			wr_q <= 4'h0;
			fill_q <= 5'h00;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 4'h1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 4'h1;
			end
			if (do_push && !do_pop) begin
				fill_q <= fill_q + 5'h01;
			end else if (do_pop && !do_push) begin
				fill_q <= fill_q - 5'h01;
			end
		end
	end

endmodule
`default_nettype wire

//--- core/level_select.v
// Interrupt fill-level comparator for receive or transmit queue
`timescale 1ns/100ps
`default_nettype none
`include "uart_cfg_map.vh"

module level_select (
	// Queue state
	input wire [4:0] fill_i,
	input wire deep_i,
	// Selection
	input wire [1:0] code_i,
	input wire empty_side_i,
	// Result
	output reg hit_o
);

	reg [4:0] amount;
	reg [4:0] thr;
	reg [4:0] limit;

	always @* begin
		amount = fill_i;
		thr = `RX8_L0;
		limit = deep_i ? `DEPTH_DEEP : `DEPTH_SHALLOW;
		if (empty_side_i) begin
			// A queue left over-full by a depth change has no free space
			amount = (fill_i >= limit) ? 5'h00 : (limit - fill_i);
		end
		case ({empty_side_i, deep_i, code_i})
			4'b0000: thr = `RX8_L0;
			4'b0001: thr = `RX8_L1;
			4'b0010: thr = `RX8_L2;
			4'b0011: thr = `RX8_L3;
			4'b0100: thr = `RX16_L0;
			4'b0101: thr = `RX16_L1;
			4'b0110: thr = `RX16_L2;
			4'b0111: thr = `RX16_L3;
			4'b1000: thr = `TX8_L0;
			4'b1001: thr = `TX8_L1;
			4'b1010: thr = `TX8_L2;
			4'b1011: thr = `TX8_L3;
			4'b1100: thr = `TX16_L0;
			4'b1101: thr = `TX16_L1;
			4'b1110: thr = `TX16_L2;
			4'b1111: thr = `TX16_L3;
			default: thr = `RX8_L0;
		endcase
		hit_o = (amount >= thr);
	end

endmodule
`default_nettype wire

//--- core/uart_chan_cfg.v
// Channel configuration: mode pointer, queue levels, flow control and error accumulation
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "uart_cfg_map.vh"

// Operation
// - Shallow receive interrupt thresholds 1, 3, 6, 8
// - Deep receive interrupt thresholds 1, 8, 12, 16
// - Receive code from mode0 bit6, mode1 bit6
// - Shallow transmit empty thresholds 8, 4, 6, 1
// - Deep transmit empty thresholds 16, 8, 12, 1
// - Pointer to mode one on reset, command 1
// - Mode one access moves pointer to two
// - Flow bit enables automatic request-to-send negation
// - Full queue plus start bit negates request-to-send
// - Latch untouched; reassert when space frees
// - Overrun and discard at tenth or eighteenth
// - Error-mode bit picks character or block
// - Character mode shows head character flags
// - Block mode ORs flags since error reset
// - Mode0 bit3 selects eight or sixteen depth
// - Empty transmit queue interrupts once enabled
// - Mode0 bits 5:4 transmit code, reset 00
module uart_chan_cfg (
	// Clock and reset
	input wire core_clk_i,
	input wire rstn_i,
	// Register port
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Receiver side
	input wire rx_start_i,
	input wire rx_done_i,
	input wire [7:0] rx_data_i,
	input wire rx_framing_i,
	input wire rx_parity_i,
	input wire rx_break_i,
	// Transmitter side
	input wire tx_pop_i,
	output reg [7:0] tx_data_o,
	output reg tx_avail_o,
	// Pins and interrupt requests
	output reg output_pin_zero_o,
	output reg rx_int_o,
	output reg tx_int_o
);

	// ----------------------------------------------------------------
	// Mode pointer states
	// ----------------------------------------------------------------
	localparam PTR_MODE0 = 3'b001;
	localparam PTR_MODE1 = 3'b010;
	localparam PTR_MODE2 = 3'b100;

	reg [2:0] ptr_q;
	reg [2:0] ptr_d;
	reg [7:0] mode_reg_zero_q;
	reg [7:0] mode_reg_one_q;
	reg [7:0] mode_reg_two_q;
	reg [7:0] output_port_latch_q;
	reg rx_en_q;
	reg tx_en_q;
	reg [10:0] hold_q;
	reg hold_valid_q;
	reg discard_q;
	reg overrun_q;
	reg [2:0] err_acc_q;
	reg rts_neg_q;

	wire queue_depth_select;
	wire rx_flow_request_control;
	wire error_accumulate_select;
	wire [1:0] rx_fill_level_select;
	wire [1:0] tx_empty_level_select;
	wire mode_acc;
	wire cmd_wr;
	wire [3:0] cmd_code;
	wire rx_flush;
	wire tx_flush;
	wire err_clear;
	wire [4:0] rx_fill;
	wire [4:0] tx_fill;
	wire rx_queue_full;
	wire tx_queue_full;
	wire [10:0] rx_head;
	wire [7:0] tx_head;
	wire rx_char_available;
	wire tx_queue_drained;
	wire tx_space_available;
	wire rx_hit;
	wire tx_hit;
	wire new_char;
	wire rx_push;
	wire [10:0] rx_push_data;
	wire rx_pop;
	wire tx_push;
	wire [2:0] head_flags;
	wire [2:0] shown_flags;
	wire [7:0] channel_status_reg;

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	assign queue_depth_select = mode_reg_zero_q[`MODE0_DEPTH_SEL];
	assign rx_fill_level_select = {mode_reg_zero_q[`MODE0_RX_LEVEL_HI], mode_reg_one_q[`MODE1_RX_LEVEL_LO]};
	assign tx_empty_level_select = {mode_reg_zero_q[`MODE0_TX_LEVEL_HI], mode_reg_zero_q[`MODE0_TX_LEVEL_LO]};
	assign rx_flow_request_control = mode_reg_one_q[`MODE1_FLOW_CTRL];
	assign error_accumulate_select = mode_reg_one_q[`MODE1_ERR_MODE];

	assign mode_acc = (wr_i || rd_i) && (addr_i == `OFS_MODE);
	assign cmd_wr = wr_i && (addr_i == `OFS_COMMAND);
	assign cmd_code = wdata_i[7:4];
	assign rx_flush = cmd_wr && (cmd_code == `CMD_RX_RESET);
	assign tx_flush = cmd_wr && (cmd_code == `CMD_TX_RESET);
	// Receiver reset also clears accumulated errors
	assign err_clear = cmd_wr && ((cmd_code == `CMD_ERR_RESET) || (cmd_code == `CMD_RX_RESET));

	// ----------------------------------------------------------------
	// Queues and level comparators
	// ----------------------------------------------------------------
	assign new_char = rx_done_i && rx_en_q && !discard_q;
	// The held character always goes first to keep arrival order
	assign rx_push = !rx_queue_full && (hold_valid_q || new_char);
	assign rx_push_data = hold_valid_q ? hold_q : {rx_break_i, rx_framing_i, rx_parity_i, rx_data_i};
	assign rx_pop = rd_i && (addr_i == `OFS_HOLDING);
	assign tx_push = wr_i && (addr_i == `OFS_HOLDING);

	char_queue #(.W(11)) u_rx_queue (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.flush_i(rx_flush),
		.deep_i(queue_depth_select),
		.push_i(rx_push),
		.push_data_i(rx_push_data),
		.pop_i(rx_pop),
		.head_o(rx_head),
		.fill_o(rx_fill),
		.full_o(rx_queue_full)
	);

	char_queue #(.W(8)) u_tx_queue (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.flush_i(tx_flush),
		.deep_i(queue_depth_select),
		.push_i(tx_push),
		.push_data_i(wdata_i),
		.pop_i(tx_pop_i),
		.head_o(tx_head),
		.fill_o(tx_fill),
		.full_o(tx_queue_full)
	);

	level_select u_rx_level (
		.fill_i(rx_fill),
		.deep_i(queue_depth_select),
		.code_i(rx_fill_level_select),
		.empty_side_i(1'b0),
		.hit_o(rx_hit)
	);

	level_select u_tx_level (
		.fill_i(tx_fill),
		.deep_i(queue_depth_select),
		.code_i(tx_empty_level_select),
		.empty_side_i(1'b1),
		.hit_o(tx_hit)
	);

	assign rx_char_available = (rx_fill != 5'h00);
	assign tx_queue_drained = (tx_fill == 5'h00);
	assign tx_space_available = !tx_queue_full;

	// ----------------------------------------------------------------
	// Error flags
	// ----------------------------------------------------------------
	assign head_flags = rx_char_available ? rx_head[10:8] : 3'b000;
	assign shown_flags = error_accumulate_select ? err_acc_q : head_flags;
	assign channel_status_reg = {shown_flags[2], shown_flags[1], shown_flags[0], overrun_q,
		tx_queue_drained, tx_space_available, rx_queue_full, rx_char_available};

	// ----------------------------------------------------------------
	// Mode pointer
	// ----------------------------------------------------------------
	always @* begin
		ptr_d = ptr_q;
		if (cmd_wr && (cmd_code == `CMD_PTR_MODE1)) begin
			ptr_d = PTR_MODE1;
		end else if (cmd_wr && (cmd_code == `CMD_PTR_MODE0)) begin
			ptr_d = PTR_MODE0;
		end else if (mode_acc) begin
			case (ptr_q)
				PTR_MODE0: ptr_d = PTR_MODE1;
				PTR_MODE1: ptr_d = PTR_MODE2;
				PTR_MODE2: ptr_d = PTR_MODE2;
				default: ptr_d = PTR_MODE1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_q <= PTR_MODE1;
			mode_reg_zero_q <= `MODE0_RESET;
			mode_reg_one_q <= `MODE1_RESET;
			mode_reg_two_q <= `MODE2_RESET;
			output_port_latch_q <= `OUT_LATCH_RESET;
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			if (wr_i && (addr_i == `OFS_MODE)) begin
				case (ptr_q)
					PTR_MODE0: mode_reg_zero_q <= wdata_i;
					PTR_MODE1: mode_reg_one_q <= wdata_i;
					PTR_MODE2: mode_reg_two_q <= wdata_i;
					default: mode_reg_one_q <= wdata_i;
				endcase
			end
			if (wr_i && (addr_i == `OFS_OUT_LATCH)) begin
				output_port_latch_q <= wdata_i;
			end
			if (cmd_wr) begin
				if (wdata_i[`CMD_RX_DIS] || rx_flush) begin
					rx_en_q <= 1'b0;
				end else if (wdata_i[`CMD_RX_EN]) begin
					rx_en_q <= 1'b1;
				end
				if (wdata_i[`CMD_TX_DIS] || tx_flush) begin
					tx_en_q <= 1'b0;
				end else if (wdata_i[`CMD_TX_EN]) begin
					tx_en_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive hold stage, overrun and error accumulation
	// ----------------------------------------------------------------
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_q <= 11'h000;
			hold_valid_q <= 1'b0;
			discard_q <= 1'b0;
			overrun_q <= 1'b0;
			err_acc_q <= 3'b000;
		end else if (rx_flush) begin
			hold_valid_q <= 1'b0;
			discard_q <= 1'b0;
			overrun_q <= 1'b0;
			err_acc_q <= 3'b000;
		end else begin
			// Character past the full queue waits here, as in a shift register
			if (new_char && (hold_valid_q || rx_queue_full)) begin
				hold_q <= {rx_break_i, rx_framing_i, rx_parity_i, rx_data_i};
				hold_valid_q <= 1'b1;
			end else if (rx_push && hold_valid_q) begin
				hold_valid_q <= 1'b0;
			end
			// A start bit with queue and hold stage both taken dooms that character
			if (rx_start_i && rx_en_q && hold_valid_q && rx_queue_full) begin
				discard_q <= 1'b1;
			end else if (rx_done_i) begin
				discard_q <= 1'b0;
			end
			if (rx_start_i && rx_en_q && hold_valid_q && rx_queue_full) begin
				overrun_q <= 1'b1;
			end else if (err_clear) begin
				overrun_q <= 1'b0;
			end
			// Set wins: a flag at the head in the error-reset command cycle is kept
			err_acc_q <= (err_clear ? 3'b000 : err_acc_q) | head_flags;
		end
	end

	// ----------------------------------------------------------------
	// Flow control and outputs
	// ----------------------------------------------------------------
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rts_neg_q <= 1'b0;
			output_pin_zero_o <= 1'b1;
			rx_int_o <= 1'b0;
			tx_int_o <= 1'b0;
			tx_data_o <= 8'h00;
			tx_avail_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			if (rx_flow_request_control && rx_start_i && rx_queue_full) begin
				rts_neg_q <= 1'b1;
			end else if (!rx_queue_full || !rx_flow_request_control) begin
				rts_neg_q <= 1'b0;
			end
			// Latch bit high drives the active-low pin low; negation overrides without touching it
			output_pin_zero_o <= !output_port_latch_q[0] || rts_neg_q;
			rx_int_o <= rx_hit && rx_char_available;
			tx_int_o <= tx_hit && tx_en_q;
			tx_data_o <= tx_head;
			tx_avail_o <= !tx_queue_drained && tx_en_q && !tx_pop_i;
			rdata_o <= 8'h00;
			if (rd_i) begin
				case (addr_i)
					`OFS_MODE: rdata_o <= (ptr_q == PTR_MODE0) ? mode_reg_zero_q :
						(ptr_q == PTR_MODE1) ? mode_reg_one_q : mode_reg_two_q;
					`OFS_STATUS: rdata_o <= channel_status_reg;
					`OFS_HOLDING: rdata_o <= rx_char_available ? rx_head[7:0] : 8'h00;
					`OFS_OUT_LATCH: rdata_o <= output_port_latch_q;
					`OFS_INT_STATE: rdata_o <= {6'h00, tx_int_o, rx_int_o};
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- verification/uart_chan_cfg_monitor.sv
// Port checks for the channel configuration block
`timescale 1ns/100ps
`default_nettype none
module uart_chan_cfg_monitor (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Queues
	input wire logic rx_start_i,
	input wire logic tx_pop_i,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_avail_o,
	// Pins and requests
	input wire logic output_pin_zero_o,
	input wire logic rx_int_o,
	input wire logic tx_int_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	wire latch_wr = wr_i && addr_i == 4'h4;
	wire cmd_wr = wr_i && addr_i == 4'h2;

	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 4'h5 |-> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_int_state_read: assert property ($past(rd_i) && $past(addr_i) == 4'h5
		|-> rdata_o == {6'h00, $past(tx_int_o), $past(rx_int_o)})
		else $error("interrupt state read wrong");
	a_pin_rise_cause: assert property ($rose(output_pin_zero_o)
		|-> $past(rx_start_i) || $past(rx_start_i, 2) || $past(latch_wr) || $past(latch_wr, 2))
		else $error("pin negated without cause");
	a_latch_clear_pin: assert property (latch_wr && !wdata_i[0] |-> ##2 output_pin_zero_o)
		else $error("pin not negated by latch");
	a_pop_avail_drop: assert property (tx_pop_i |=> !tx_avail_o)
		else $error("avail not dropped after pop");
	a_head_stable: assert property ((tx_avail_o && !tx_pop_i) ##1 tx_avail_o |-> $stable(tx_data_o))
		else $error("transmit head moved without pop");
	a_rx_flush_int: assert property (cmd_wr && wdata_i[7:4] == 4'h2 |-> ##2 !rx_int_o)
		else $error("receive request after flush");
	a_tx_flush_int: assert property (cmd_wr && wdata_i[7:4] == 4'h3 |-> ##2 !tx_int_o && !tx_avail_o)
		else $error("transmit request after reset");

	c_pin_rise: cover property ($rose(output_pin_zero_o));
	c_rx_int: cover property ($rose(rx_int_o));
	c_pop: cover property (tx_pop_i);
endmodule
bind uart_chan_cfg uart_chan_cfg_monitor mon_u (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .rx_start_i, .tx_pop_i, .tx_data_o, .tx_avail_o, .output_pin_zero_o, .rx_int_o, .tx_int_o);
`default_nettype wire

//--- verification/remote_tx.sv
// Remote serial transmitter seen as start and character pulses
`timescale 1ns/100ps
`default_nettype none
module remote_tx (
	// Clock and flow input
	input wire logic core_clk_i,
	input wire logic cts_n_i,
	// Character side
	output logic start_o,
	output logic done_o,
	output logic [7:0] data_o,
	output logic [2:0] flags_o
);
	initial begin
		start_o = 1'b0;
		done_o = 1'b0;
		data_o = 8'h00;
		flags_o = 3'b000;
	end
	// Waits while request-to-send is negated; go ignores it to force an overrun
	task automatic send(input logic [7:0] v, input logic [2:0] f, input bit go, input int gap);
		int n;
		n = 0;
		while (cts_n_i && !go && n < 400) begin
			@(posedge core_clk_i);
			n++;
		end
		start_o <= 1'b1;
		@(posedge core_clk_i);
		start_o <= 1'b0;
		repeat (gap + 2) @(posedge core_clk_i);
		data_o <= v;
		flags_o <= f;
		done_o <= 1'b1;
		@(posedge core_clk_i);
		// Released lines show garbage, not the last character
		done_o <= 1'b0;
		data_o <= ~v;
		flags_o <= ~f;
	endtask
endmodule
`default_nettype wire

//--- verification/uart_chan_cfg_test.sv
// Self-checking bench for the channel configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module uart_chan_cfg_test;
	logic core_clk_i, rstn_i, wr_i, rd_i, tx_pop_i, rx_start_i, rx_done_i, rd_d;
	logic tx_avail_o, output_pin_zero_o, rx_int_o, tx_int_o;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o, rx_data_i, tx_data_o, lf, first, e, m;
	logic [2:0] rx_flags;
	logic [7:0] exp_q[$], msk_q[$], d[9];
	int miscompares, samples_checked, cyc, n, c, dp, fl, dep;
	int rxt[2][4] = '{'{1, 3, 6, 8}, '{1, 8, 12, 16}};
	int txt[2][4] = '{'{8, 4, 6, 1}, '{16, 8, 12, 1}};

	uart_chan_cfg dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_start_i(rx_start_i), .rx_done_i(rx_done_i),
		.rx_data_i(rx_data_i), .rx_framing_i(rx_flags[1]), .rx_parity_i(rx_flags[0]),
		.rx_break_i(rx_flags[2]), .tx_pop_i(tx_pop_i), .tx_data_o(tx_data_o), .tx_avail_o(tx_avail_o),
		.output_pin_zero_o(output_pin_zero_o), .rx_int_o(rx_int_o), .tx_int_o(tx_int_o));
	remote_tx far_u (.core_clk_i(core_clk_i), .cts_n_i(output_pin_zero_o), .start_o(rx_start_i),
		.done_o(rx_done_i), .data_o(rx_data_i), .flags_o(rx_flags));

	// ----
	// Bus tasks
	// ----
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic idle(input int k);
		repeat (k) @(posedge core_clk_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		idle(1);
		wr_i <= 1'b0;
		idle(1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] v, input logic [7:0] k);
		exp_q.push_back(v & k);
		msk_q.push_back(k);
		addr_i <= a;
		rd_i <= 1'b1;
		idle(1);
		rd_i <= 1'b0;
		idle(1);
	endtask
	task automatic modes(input logic [7:0] m0, input logic [7:0] m1);
		wr(4'h2, 8'hB0);
		wr(4'h0, m0);
		wr(4'h2, 8'h10);
		wr(4'h0, m1);
	endtask
	task automatic chr(input logic [7:0] v, input logic [2:0] f, input bit go);
		far_u.send(v, f, go, int'(lf[1:0]));
		idle(3);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----
	// Result watcher and hang guard
	// ----
	always @(posedge core_clk_i) begin
		rd_d <= rd_i;
		cyc++;
		if (rd_d) begin
			m = msk_q.pop_front();
			e = exp_q.pop_front();
			`CHK("rdata", e, rdata_o & m)
		end
		if (cyc == 40000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// ----
	// Scenarios
	// ----
	initial begin
		{rstn_i, wr_i, rd_i, tx_pop_i, addr_i, wdata_i} = '0;
		lf = 8'h0E;
		idle(16);
		rstn_i <= 1'b1;
		rd(4'h5, 8'h00, 8'hFF);
		wr(4'h4, 8'h00);
		wr(4'h4, 8'h01);
		wr(4'h2, 8'h04);
		rd(4'h5, 8'h02, 8'h02);
		lf = lfsr(lf);
		wr(4'h3, lf);
		rd(4'h5, 8'h00, 8'h02);
		wr(4'h0, 8'h40);
		wr(4'h0, 8'h5A);
		wr(4'h2, 8'h10);
		rd(4'h0, 8'h40, 8'hFF);
		rd(4'h0, 8'h5A, 8'hFF);
		rd(4'hF, 8'h00, 8'hFF);
		rd(4'h4, 8'h01, 8'hFF);
		$display("test reset and pointer done");
		for (dp = 0; dp < 2; dp++) for (c = 0; c < 4; c++) begin
			dep = dp ? 16 : 8;
			wr(4'h2, 8'h20);
			wr(4'h2, 8'h01);
			modes({1'b0, c[1], 2'b00, dp[0], 3'b000}, {1'b0, c[0], 6'h00});
			for (n = 1; n <= dep; n++) begin
				lf = lfsr(lf);
				chr(lf, 3'b000, 1'b0);
				rd(4'h5, {7'h00, n >= rxt[dp][c]}, 8'h01);
				`CHK("rx_int", n >= rxt[dp][c], rx_int_o)
			end
		end
		$display("test receive levels done");
		for (dp = 0; dp < 2; dp++) for (c = 0; c < 4; c++) begin
			dep = dp ? 16 : 8;
			wr(4'h2, 8'h30);
			wr(4'h2, 8'h04);
			modes({2'b00, c[1:0], dp[0], 3'b000}, 8'h00);
			for (n = 0; n <= dep; n++) begin
				lf = lfsr(lf);
				if (n == 1)
					first = lf;
				if (n > 0)
					wr(4'h3, lf);
				rd(4'h5, {6'h00, (dep - n) >= txt[dp][c], 1'b0}, 8'h02);
				`CHK("tx_int", (dep - n) >= txt[dp][c], tx_int_o)
			end
		end
		`CHK("tx_avail", 1'b1, tx_avail_o)
		`CHK("tx_data", first, tx_data_o)
		tx_pop_i <= 1'b1;
		idle(1);
		tx_pop_i <= 1'b0;
		idle(3);
		rd(4'h5, 8'h02, 8'h02);
		$display("test transmit levels done");
		for (fl = 0; fl < 2; fl++) begin
			wr(4'h2, 8'h20);
			wr(4'h2, 8'h01);
			modes(8'h00, {fl[0], 7'h00});
			for (n = 0; n < 9; n++) begin
				lf = lfsr(lf);
				d[n] = lf;
				chr(lf, 3'b000, 1'b0);
			end
			`CHK("rts_pin", fl[0], output_pin_zero_o)
		end
		rd(4'h4, 8'h01, 8'hFF);
		chr(8'h3C, 3'b000, 1'b1);
		rd(4'h1, 8'h10, 8'h10);
		rd(4'h3, d[0], 8'hFF);
		rd(4'h3, d[1], 8'hFF);
		idle(3);
		`CHK("rts_pin", 1'b0, output_pin_zero_o)
		for (n = 2; n < 9; n++)
			rd(4'h3, d[n], 8'hFF);
		rd(4'h3, 8'h00, 8'hFF);
		wr(4'h2, 8'h20);
		wr(4'h2, 8'h01);
		modes(8'h08, 8'h80);
		for (n = 0; n < 17; n++) begin
			lf = lfsr(lf);
			chr(lf, 3'b000, 1'b0);
		end
		`CHK("rts_pin", 1'b1, output_pin_zero_o)
		rd(4'h1, 8'h02, 8'h12);
		$display("test flow control done");
		wr(4'h2, 8'h20);
		wr(4'h2, 8'h01);
		modes(8'h00, 8'h00);
		chr(d[0], 3'b010, 1'b0);
		chr(d[1], 3'b001, 1'b0);
		rd(4'h1, 8'h40, 8'hE0);
		rd(4'h3, d[0], 8'hFF);
		rd(4'h1, 8'h20, 8'hE0);
		rd(4'h3, d[1], 8'hFF);
		modes(8'h00, 8'h20);
		wr(4'h2, 8'h40);
		chr(d[2], 3'b010, 1'b0);
		chr(d[3], 3'b100, 1'b0);
		rd(4'h3, d[2], 8'hFF);
		rd(4'h3, d[3], 8'hFF);
		rd(4'h1, 8'hC0, 8'hE0);
		wr(4'h2, 8'h40);
		rd(4'h1, 8'h00, 8'hE0);
		idle(2);
		$display("test error modes done");
		results();
	end
endmodule
`default_nettype wire
